// File: mms_map.vh
`ifndef MMS_MAP_VH
`define MMS_MAP_VH

// Register byte offsets
`define MMS_OFS_CTRL       12'h000
`define MMS_OFS_NUM        12'h004
`define MMS_OFS_TRIG       12'h008
`define MMS_OFS_STAT       12'h00c
`define MMS_OFS_PASS       12'h010
`define MMS_OFS_SKIP       12'h014
`define MMS_OFS_TBL        12'h100
`define MMS_WORDS_PER_CMD  3

// Command entry fields, word 0
`define MMS_F_DBADDR       17:0
`define MMS_F_MODE         21:20
`define MMS_F_SWAP         25:24
// Word 1
`define MMS_F_INTV         15:0
`define MMS_F_COUNT        25:16
// Word 2
`define MMS_F_NODE         7:0
`define MMS_F_FUNC         15:8
`define MMS_F_REMOTE       31:16

// Reset values
`define MMS_RST_RUN        1'h0
`define MMS_RST_NUM        5'h00

// Execution modes
`define MMS_MODE_DIS       2'h0
`define MMS_MODE_CONT      2'h1
`define MMS_MODE_EVT       2'h2
`define MMS_MODE_COND      2'h3

// Swap codes
`define MMS_SWAP_NONE      2'h0
`define MMS_SWAP_WORD      2'h1
`define MMS_SWAP_BOTH      2'h2
`define MMS_SWAP_BYTE      2'h3

// Function codes
`define MMS_FC_RD_COIL     8'h01
`define MMS_FC_RD_INP      8'h02
`define MMS_FC_RD_HREG     8'h03
`define MMS_FC_RD_IREG     8'h04
`define MMS_FC_WR_COIL     8'h05
`define MMS_FC_WR_REG      8'h06
`define MMS_FC_WR_COILS    8'h0f
`define MMS_FC_WR_REGS     8'h10

// Limits
`define MMS_WORD_ADDR_MAX  18'h0270f
`define MMS_BIT_ADDR_MAX   18'h270ff
`define MMS_WORD_CNT_MAX   10'h07d
`define MMS_BIT_CNT_MAX    10'h320
`define MMS_NODE_BCAST     8'h00

// Bus responses
`define MMS_RESP_OKAY      2'h0
`define MMS_RESP_SLVERR    2'h2

// Poll interval unit: one second at the core clock
`define MMS_TICK_S         1
`define MMS_CLK_HZ         20000000
`define MMS_TICK_CYC       (`MMS_TICK_S * `MMS_CLK_HZ)

`endif

// File: mms_cmd_ram.v
`timescale 1ns/1ps
module mms_cmd_ram #(
  parameter AW    = 6,
  parameter DEPTH = 48
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire [3:0]    we,
  input  wire [AW-1:0] waddr,
  input  wire [31:0]   wdata,
  input  wire [AW-1:0] raddr,
  output wire [31:0]   rdata
);
  reg [31:0] mem [0:DEPTH-1];
  reg [31:0] rdata_r;
  integer    b;

  always @(posedge clk) begin
    for (b = 0; b < 4; b = b + 1) begin
      if (we[b]) begin
        mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= mem[raddr];
    end
  end

  assign rdata = rdata_r;
endmodule // mms_cmd_ram

// File: mms_cmd_sched.v
// Functional notes
// - Mode 0 off, 1 continuous, 2 event, 3 conditional
// - Disabled entry still runs on manual trigger
// - Continuous, interval zero: issue every pass
// - Continuous, nonzero interval: issue on expiry, restart
// - Event mode issues on data change, writes only
// - Conditional issues on bit change, clears bits
// - Internal address is data source or destination
// - Word address to 9999 for word functions
// - Bit address accepted up to 159999
// - Poll interval is minimum spacing in seconds
// - Count 1-125 words or 1-800 bits
// - Functions 5 and 6 move exactly one point
// - Swap codes 0 none, 1 words, 2 both, 3 bytes
// - Reordering works on four-byte groups
// - Node 1-255, zero sends as broadcast
// - Only functions 1,2,3,4,5,6,15,16 supported
// - Remote address is zero-based offset
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "mms_map.vh"
module mms_cmd_sched #(
  parameter N           = 16,
  parameter IDXW        = 4,
  parameter MAW         = 6,
  parameter TICK_CYCLES = `MMS_TICK_CYC
) (
  input  wire            clk,
  input  wire            reset_n,
  input  wire [11:0]     s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output wire [1:0]      s_axi_bresp,
  output wire            s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [11:0]     s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output wire [31:0]     s_axi_rdata,
  output wire [1:0]      s_axi_rresp,
  output wire            s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire [N-1:0]    event_chg,
  input  wire [N-1:0]    cond_chg,
  output wire            req_valid,
  input  wire            req_ready,
  output wire [IDXW-1:0] req_idx,
  output wire [7:0]      req_node,
  output wire            req_bcast,
  output wire [7:0]      req_func,
  output wire [17:0]     req_db_addr,
  output wire            req_db_bit,
  output wire [9:0]      req_count,
  output wire [15:0]     req_remote,
  output wire [1:0]      req_swap,
  output wire            cond_clr,
  output wire [IDXW-1:0] cond_clr_idx,
  input  wire            sw_in_valid,
  input  wire [1:0]      sw_in_code,
  input  wire [31:0]     sw_in_data,
  output wire            sw_out_valid,
  output wire [31:0]     sw_out_data
);
  localparam [2:0]  S_IDLE  = 3'h0;
  localparam [2:0]  S_FETCH = 3'h1;
  localparam [2:0]  S_EVAL  = 3'h2;
  localparam [2:0]  S_ISSUE = 3'h3;
  localparam [2:0]  S_NEXT  = 3'h4;
  localparam        TBL_END = `MMS_OFS_TBL + N * `MMS_WORDS_PER_CMD * 4;
  localparam        TICK_LAST = TICK_CYCLES - 1;

  function fc_supported;
    input [7:0] fc;
    begin
      case (fc)
        `MMS_FC_RD_COIL, `MMS_FC_RD_INP, `MMS_FC_RD_HREG, `MMS_FC_RD_IREG,
        `MMS_FC_WR_COIL, `MMS_FC_WR_REG, `MMS_FC_WR_COILS, `MMS_FC_WR_REGS:
          fc_supported = 1'b1;
        default: fc_supported = 1'b0;
      endcase
    end
  endfunction

  function fc_is_bit;
    input [7:0] fc;
    begin
      fc_is_bit = (fc == `MMS_FC_RD_COIL) || (fc == `MMS_FC_RD_INP) ||
                  (fc == `MMS_FC_WR_COIL) || (fc == `MMS_FC_WR_COILS);
    end
  endfunction

  function fc_is_single;
    input [7:0] fc;
    begin
      fc_is_single = (fc == `MMS_FC_WR_COIL) || (fc == `MMS_FC_WR_REG);
    end
  endfunction

  function [31:0] swap_group;
    input [1:0]  code;
    input [31:0] d;
    begin
      case (code)
        `MMS_SWAP_WORD: swap_group = {d[15:0], d[31:16]};
        `MMS_SWAP_BOTH: swap_group = {d[7:0], d[15:8], d[23:16], d[31:24]};
        `MMS_SWAP_BYTE: swap_group = {d[23:16], d[31:24], d[7:0], d[15:8]};
        default:        swap_group = d;
      endcase
    end
  endfunction

  function [IDXW-1:0] first_set;
    input [N-1:0] v;
    integer       k;
    begin
      first_set = {IDXW{1'b0}};
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[IDXW-1:0];
        end
      end
    end
  endfunction

  // Bus slave
  reg            awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  reg  [1:0]     bresp_r, rresp_r;
  reg  [31:0]    rdata_r;
  reg            aw_held_r, w_held_r;
  reg  [11:0]    aw_addr_r;
  reg  [31:0]    w_data_r;
  reg  [3:0]     w_strb_r;
  reg            run_r;
  reg  [IDXW:0]  num_r;
  reg  [31:0]    pass_cnt_r, skip_cnt_r;

  wire        wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire        tbl_wr  = (aw_addr_r >= `MMS_OFS_TBL) && (aw_addr_r < TBL_END);
  wire [11:0] tbl_off = aw_addr_r - `MMS_OFS_TBL;
  wire        wr_map  = tbl_wr || ((aw_addr_r <= `MMS_OFS_SKIP) && (aw_addr_r[1:0] == 2'h0));
  wire        trig_wr = wr_fire && (aw_addr_r == `MMS_OFS_TRIG) && w_strb_r[0];
  wire [3:0]  mem_we  = (wr_fire && tbl_wr) ? w_strb_r : 4'h0;

  // Scheduler state
  reg  [2:0]      state_r;
  reg  [IDXW-1:0] cur_idx_r, scan_idx_r;
  reg             man_r;
  reg  [1:0]      wcnt_r;
  reg  [31:0]     w0_r, w1_r, w2_r;
  reg  [N-1:0]    man_pend_r, evt_pend_r, cond_pend_r;
  reg  [16:0]     tmr_r [0:N-1];
  reg  [24:0]     tick_cnt_r;
  reg             tick_r;
  reg             req_valid_r, req_bcast_r, req_db_bit_r, cond_clr_r;
  reg  [IDXW-1:0] req_idx_r, cond_clr_idx_r;
  reg  [7:0]      req_node_r, req_func_r;
  reg  [17:0]     req_db_addr_r;
  reg  [9:0]      req_count_r;
  reg  [15:0]     req_remote_r;
  reg  [1:0]      req_swap_r;
  reg             sw_valid_r;
  reg  [31:0]     sw_data_r;

  wire [31:0]     mem_rdata;
  wire [MAW+1:0]  idx_ext  = {{(MAW+2-IDXW){1'b0}}, cur_idx_r};
  wire [MAW+1:0]  base_ext = (idx_ext << 1) + idx_ext;
  wire [1:0]      wsel     = (wcnt_r == 2'h3) ? 2'h2 : wcnt_r;
  wire [MAW-1:0]  mem_raddr = base_ext[MAW-1:0] + {{(MAW-2){1'b0}}, wsel};

  mms_cmd_ram #(
    .AW    (MAW),
    .DEPTH (N * `MMS_WORDS_PER_CMD)
  ) u_ram (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (mem_we),
    .waddr   (tbl_off[MAW+1:2]),
    .wdata   (w_data_r),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // Entry decode and validation
  wire [1:0]  e_mode  = w0_r[`MMS_F_MODE];
  wire [17:0] e_addr  = w0_r[`MMS_F_DBADDR];
  wire [15:0] e_intv  = w1_r[`MMS_F_INTV];
  wire [9:0]  e_cnt   = w1_r[`MMS_F_COUNT];
  wire [7:0]  e_func  = w2_r[`MMS_F_FUNC];
  wire        e_bit   = fc_is_bit(e_func);
  wire        e_one   = fc_is_single(e_func);
  wire        e_wr    = e_one || (e_func == `MMS_FC_WR_COILS) || (e_func == `MMS_FC_WR_REGS);
  wire        addr_ok = e_bit ? (e_addr <= `MMS_BIT_ADDR_MAX) :
                                (e_addr <= `MMS_WORD_ADDR_MAX);
  wire        cnt_ok  = e_one || ((e_cnt != 10'h000) &&
                        (e_cnt <= (e_bit ? `MMS_BIT_CNT_MAX : `MMS_WORD_CNT_MAX)));
  wire        mode_ok = man_r || (e_mode == `MMS_MODE_DIS) || (e_mode == `MMS_MODE_CONT) ||
                        ((e_mode == `MMS_MODE_EVT) && e_wr) ||
                        ((e_mode == `MMS_MODE_COND) && e_wr && e_bit);
  wire        cfg_ok  = fc_supported(e_func) && addr_ok && cnt_ok && mode_ok;
  wire        due     = man_r ? 1'b1 :
                        (e_mode == `MMS_MODE_CONT) ? ((e_intv == 16'h0000) ||
                                                      (tmr_r[cur_idx_r] == 17'h00000)) :
                        (e_mode == `MMS_MODE_EVT)  ? evt_pend_r[cur_idx_r] :
                        (e_mode == `MMS_MODE_COND) ? cond_pend_r[cur_idx_r] :
                        1'b0;
  wire        go      = cfg_ok && due;
  wire        issue   = (state_r == S_ISSUE) && req_ready;
  wire [N-1:0] cur_oh = {{(N-1){1'b0}}, 1'b1} << cur_idx_r;
  wire [N-1:0] trig_oh = {{(N-1){1'b0}}, 1'b1} << w_data_r[IDXW-1:0];
  wire        man_done = man_r && (issue || ((state_r == S_EVAL) && !go));
  wire [N-1:0] man_clr = cur_oh & {N{man_done}};
  wire [N-1:0] ent_clr = cur_oh & {N{issue}};
  wire [IDXW:0] scan_inc = {1'b0, scan_idx_r} + {{IDXW{1'b0}}, 1'b1};
  wire [16:0] tmr_load = {1'b0, e_intv} + {16'h0000, (e_intv != 16'h0000)};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MMS_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      run_r     <= `MMS_RST_RUN;
      num_r     <= `MMS_RST_NUM;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? `MMS_RESP_OKAY : `MMS_RESP_SLVERR;
        if ((aw_addr_r == `MMS_OFS_CTRL) && w_strb_r[0]) begin
          run_r <= w_data_r[0];
        end
        if ((aw_addr_r == `MMS_OFS_NUM) && w_strb_r[0]) begin
          num_r <= (w_data_r[IDXW:0] > N) ? N[IDXW:0] : w_data_r[IDXW:0];
        end
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `MMS_RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= `MMS_RESP_OKAY;
      case (s_axi_araddr)
        `MMS_OFS_CTRL: rdata_r <= {31'h00000000, run_r};
        `MMS_OFS_NUM:  rdata_r <= {{(31-IDXW){1'b0}}, num_r};
        `MMS_OFS_STAT: rdata_r <= {{(16-IDXW){1'b0}}, cur_idx_r, 5'h00, state_r,
                                   6'h00, req_valid_r, run_r};
        `MMS_OFS_PASS: rdata_r <= pass_cnt_r;
        `MMS_OFS_SKIP: rdata_r <= skip_cnt_r;
        default: begin
          // Table words are write-only; the read port belongs to the scheduler
          rdata_r <= 32'h00000000;
          if (!((s_axi_araddr == `MMS_OFS_TRIG) ||
                ((s_axi_araddr >= `MMS_OFS_TBL) && (s_axi_araddr < TBL_END)))) begin
            rresp_r <= `MMS_RESP_SLVERR;
          end
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Pending flags: a new set wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      man_pend_r  <= {N{1'b0}};
      evt_pend_r  <= {N{1'b0}};
      cond_pend_r <= {N{1'b0}};
    end else begin
      man_pend_r  <= (man_pend_r & ~man_clr) | (trig_wr ? trig_oh : {N{1'b0}});
      evt_pend_r  <= (evt_pend_r & ~ent_clr) | event_chg;
      cond_pend_r <= (cond_pend_r & ~ent_clr) | cond_chg;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 25'h0000000;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 25'h0000000 : tick_cnt_r + 25'h0000001;
    end
  end

  // Loading one past the interval keeps the spacing a true minimum despite tick phase
  integer i;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < N; i = i + 1) begin
        tmr_r[i] <= 17'h00000;
      end
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        if (issue && (cur_idx_r == i) && (e_mode == `MMS_MODE_CONT)) begin
          tmr_r[i] <= tmr_load;
        end else if (tick_r && (tmr_r[i] != 17'h00000)) begin
          tmr_r[i] <= tmr_r[i] - 17'h00001;
        end
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      cur_idx_r <= {IDXW{1'b0}};
      scan_idx_r <= {IDXW{1'b0}};
      man_r <= 1'b0;
      wcnt_r <= 2'h0;
      w0_r <= 32'h00000000;
      w1_r <= 32'h00000000;
      w2_r <= 32'h00000000;
      pass_cnt_r <= 32'h00000000;
      skip_cnt_r <= 32'h00000000;
      req_valid_r <= 1'b0;
      req_idx_r <= {IDXW{1'b0}};
      req_node_r <= 8'h00;
      req_bcast_r <= 1'b0;
      req_func_r <= 8'h00;
      req_db_addr_r <= 18'h00000;
      req_db_bit_r <= 1'b0;
      req_count_r <= 10'h000;
      req_remote_r <= 16'h0000;
      req_swap_r <= 2'h0;
      cond_clr_r <= 1'b0;
      cond_clr_idx_r <= {IDXW{1'b0}};
    end else begin
      cond_clr_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          wcnt_r <= 2'h0;
          if (man_pend_r != {N{1'b0}}) begin
            cur_idx_r <= first_set(man_pend_r);
            man_r <= 1'b1;
            state_r <= S_FETCH;
          end else if ({1'b0, scan_idx_r} >= num_r) begin
            scan_idx_r <= {IDXW{1'b0}};
          end else if (run_r) begin
            cur_idx_r <= scan_idx_r;
            man_r <= 1'b0;
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          wcnt_r <= wcnt_r + 2'h1;
          if (wcnt_r != 2'h0) begin
            w0_r <= w1_r;
            w1_r <= w2_r;
            w2_r <= mem_rdata;
          end
          if (wcnt_r == 2'h3) begin
            state_r <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (go) begin
            req_valid_r <= 1'b1;
            req_idx_r <= cur_idx_r;
            req_node_r <= w2_r[`MMS_F_NODE];
            req_bcast_r <= (w2_r[`MMS_F_NODE] == `MMS_NODE_BCAST);
            req_func_r <= e_func;
            req_db_addr_r <= e_addr;
            req_db_bit_r <= e_bit;
            req_count_r <= e_one ? 10'h001 : e_cnt;
            req_remote_r <= w2_r[`MMS_F_REMOTE];
            req_swap_r <= w0_r[`MMS_F_SWAP];
            state_r <= S_ISSUE;
          end else begin
            if (!cfg_ok) begin
              skip_cnt_r <= skip_cnt_r + 32'h00000001;
            end
            state_r <= S_NEXT;
          end
        end
        S_ISSUE: begin
          if (req_ready) begin
            req_valid_r <= 1'b0;
            if (e_mode == `MMS_MODE_COND) begin
              cond_clr_r <= 1'b1;
              cond_clr_idx_r <= cur_idx_r;
            end
            state_r <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (!man_r) begin
            if (scan_inc >= num_r) begin
              scan_idx_r <= {IDXW{1'b0}};
              pass_cnt_r <= pass_cnt_r + 32'h00000001;
            end else begin
              scan_idx_r <= scan_inc[IDXW-1:0];
            end
          end
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Swap path, one 32-bit group per beat
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_valid_r <= 1'b0;
      sw_data_r  <= 32'h00000000;
    end else begin
      sw_valid_r <= sw_in_valid;
      if (sw_in_valid) begin
        sw_data_r <= swap_group(sw_in_code, sw_in_data);
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign req_valid     = req_valid_r;
  assign req_idx       = req_idx_r;
  assign req_node      = req_node_r;
  assign req_bcast     = req_bcast_r;
  assign req_func      = req_func_r;
  assign req_db_addr   = req_db_addr_r;
  assign req_db_bit    = req_db_bit_r;
  assign req_count     = req_count_r;
  assign req_remote    = req_remote_r;
  assign req_swap      = req_swap_r;
  assign cond_clr      = cond_clr_r;
  assign cond_clr_idx  = cond_clr_idx_r;
  assign sw_out_valid  = sw_valid_r;
  assign sw_out_data   = sw_data_r;
endmodule // mms_cmd_sched

// File: mms_cmd_sched_monitor.sv
`timescale 1ns/1ps
module mms_cmd_sched_monitor #(
  parameter N    = 16,
  parameter IDXW = 4
) (
  input logic            clk,
  input logic            reset_n,
  input logic            req_valid,
  input logic            req_ready,
  input logic [IDXW-1:0] req_idx,
  input logic [7:0]      req_node,
  input logic            req_bcast,
  input logic [7:0]      req_func,
  input logic [17:0]     req_db_addr,
  input logic            req_db_bit,
  input logic [9:0]      req_count,
  input logic            cond_clr,
  input logic [IDXW-1:0] cond_clr_idx,
  input logic            sw_in_valid,
  input logic [1:0]      sw_in_code,
  input logic [31:0]     sw_in_data,
  input logic            sw_out_valid,
  input logic [31:0]     sw_out_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  function automatic logic [31:0] swp(logic [31:0] d, logic [1:0] c);
    case (c)
      2'h1: return {d[15:0], d[31:16]};
      2'h2: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h3: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      default: return d;
    endcase
  endfunction
  wire bit_fc = req_func inside {8'h01, 8'h02, 8'h05, 8'h0f};
  wire one_fc = req_func inside {8'h05, 8'h06};
  wire wrd_fc = req_func inside {8'h03, 8'h04, 8'h10};
  sequence s_hold; req_valid && !req_ready; endsequence
  sequence s_hs; req_valid && req_ready; endsequence
  property p_hold;
    s_hold |=> req_valid && $stable({req_idx, req_func, req_db_addr, req_count, req_node});
  endproperty
  property p_bcast; req_valid |-> req_bcast == (req_node == 8'h00); endproperty
  property p_dbbit; req_valid |-> req_db_bit == bit_fc; endproperty
  property p_one; req_valid && one_fc |-> req_count == 10'h001; endproperty
  property p_fc; req_valid |-> bit_fc || wrd_fc || req_func == 8'h06; endproperty
  property p_cnt;
    req_valid && !one_fc |-> req_count != 10'h0 && req_count <= (wrd_fc ? 10'h07d : 10'h320);
  endproperty
  property p_addr; req_valid |-> req_db_addr <= (req_db_bit ? 18'h270ff : 18'h0270f); endproperty
  property p_swap;
    sw_in_valid |=> sw_out_valid && sw_out_data == swp($past(sw_in_data), $past(sw_in_code));
  endproperty
  // A stray clear would lose a pending condition
  property p_clr;
    cond_clr |-> $past(req_valid && req_ready) && cond_clr_idx == $past(req_idx);
  endproperty
  property p_gap; s_hs |=> !req_valid; endproperty
  a_hold: assert property (p_hold) else $error("request changed while waiting");
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
  a_dbbit: assert property (p_dbbit) else $error("bit or word address kind wrong");
  a_one: assert property (p_one) else $error("single point count not one");
  a_fc: assert property (p_fc) else $error("unsupported function issued");
  a_cnt: assert property (p_cnt) else $error("count out of range issued");
  a_addr: assert property (p_addr) else $error("internal address out of range");
  a_swap: assert property (p_swap) else $error("swap result wrong");
  a_clr: assert property (p_clr) else $error("clear without issue");
  a_gap: assert property (p_gap) else $error("request repeated at once");
endmodule // mms_cmd_sched_monitor
bind mms_cmd_sched mms_cmd_sched_monitor #(.N(N), .IDXW(IDXW)) u_mon (
  .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
  .req_idx(req_idx), .req_node(req_node), .req_bcast(req_bcast), .req_func(req_func),
  .req_db_addr(req_db_addr), .req_db_bit(req_db_bit), .req_count(req_count),
  .cond_clr(cond_clr), .cond_clr_idx(cond_clr_idx), .sw_in_valid(sw_in_valid),
  .sw_in_code(sw_in_code), .sw_in_data(sw_in_data), .sw_out_valid(sw_out_valid),
  .sw_out_data(sw_out_data));

// File: mms_slave_model.sv
`timescale 1ns/1ps
module mms_slave_model (
  input  logic clk,
  input  logic reset_n,
  input  logic req_valid,
  input  logic slow,
  output logic req_ready
);
  logic [1:0] w_r;
  // A slow slave keeps the scheduler waiting with a request held
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
      w_r       <= 2'h0;
    end else if (req_valid && req_ready) begin
      req_ready <= 1'b0;
      w_r       <= 2'h0;
    end else if (req_valid) begin
      w_r       <= w_r + 2'h1;
      req_ready <= !slow || w_r == 2'h2;
    end
  end
endmodule // mms_slave_model

// File: mms_cmd_sched_tb_top.sv
`timescale 1ns/1ps
module mms_cmd_sched_tb_top;
  logic        clk = 0, reset_n = 0, slow = 0, sw_v = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, req_valid, req_ready;
  logic        req_bcast, req_db_bit, cond_clr, sw_out_valid;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, sw_d = 0, rdata, sw_out_data, d;
  logic [1:0]  bresp, rresp, r, sw_c = 0, req_swap;
  logic [15:0] ev = 0, cd = 0, req_remote;
  logic [3:0]  req_idx, cond_clr_idx;
  logic [7:0]  req_node, req_func;
  logic [17:0] req_db_addr;
  logic [9:0]  req_count;
  int          fail_count = 0, checked = 0, cyc = 0, t6 = 0, gap6 = 0;
  int          hs [16];
  int          q [$] = '{1, 2, 3, 4, 5, 7};
  logic [31:0] sx [4] = '{32'h11223344, 32'h33441122, 32'h44332211, 32'h22114433};
  wire  [63:0] fv = {req_node, req_func, req_db_addr, req_db_bit, req_count, req_remote,
                     req_swap, req_bcast};
  always #25 clk = ~clk;
  mms_cmd_sched #(.TICK_CYCLES(20)) dut (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_chg(ev), .cond_chg(cd), .req_valid(req_valid), .req_ready(req_ready),
    .req_idx(req_idx), .req_node(req_node), .req_bcast(req_bcast), .req_func(req_func),
    .req_db_addr(req_db_addr), .req_db_bit(req_db_bit), .req_count(req_count),
    .req_remote(req_remote), .req_swap(req_swap), .cond_clr(cond_clr),
    .cond_clr_idx(cond_clr_idx), .sw_in_valid(sw_v), .sw_in_code(sw_c), .sw_in_data(sw_d),
    .sw_out_valid(sw_out_valid), .sw_out_data(sw_out_data));
  mms_slave_model slv (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .slow(slow),
    .req_ready(req_ready));
  task end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input string nm, input [63:0] e, input [63:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    fork
      begin do @(posedge clk); while (!awready); awvalid <= 0; end
      begin do @(posedge clk); while (!wready); wvalid <= 0; end
    join
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task rd(input [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  // Remote offset fixed at 7 keeps the table short
  task ent(input [3:0] i, input [17:0] db, input [1:0] md, input [1:0] sw,
           input [15:0] iv, input [9:0] cn, input [7:0] nd, input [7:0] fc);
    wr(12'h100 + i * 12, {6'h0, sw, 2'h0, md, 2'h0, db});
    wr(12'h104 + i * 12, {6'h0, cn, iv});
    wr(12'h108 + i * 12, {16'h0007, fc, nd});
  endtask
  task wreq(input [3:0] i);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (!(req_valid && req_ready && req_idx == i) && n < 600);
    cmp("req_idx", i, req_valid && req_ready ? req_idx : 5'h1f);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (req_valid && req_ready) begin
      hs[req_idx]++;
      if (req_idx == 6) begin gap6 = cyc - t6; t6 = cyc; end
    end
    if (cyc > 30000) begin fail_count++; end_of_test(); end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    rd(12'h020); cmp("rresp", 2, r);
    ent(0, 100, 1, 1, 0, 10, 5, 2);
    ent(1, 150000, 0, 0, 0, 50, 0, 5);
    ent(2, 0, 1, 0, 0, 1, 1, 7);
    ent(3, 9999, 2, 3, 0, 4, 9, 16);
    ent(4, 20, 3, 0, 0, 800, 2, 15);
    ent(5, 0, 2, 0, 0, 1, 1, 1);
    ent(6, 5, 1, 2, 2, 125, 3, 4);
    ent(7, 10000, 1, 0, 0, 1, 1, 3);
    wr(12'h004, 8);
    wr(12'h000, 1);
    $display("test config done");
    wreq(0); cmp("f0", {8'd5, 8'h02, 18'd100, 1'b1, 10'd10, 16'd7, 2'd1, 1'b0}, fv);
    wreq(0);
    wreq(6); cmp("f6", {8'd3, 8'h04, 18'd5, 1'b0, 10'd125, 16'd7, 2'd2, 1'b0}, fv);
    wreq(6);
    @(posedge clk);
    cmp("gap6", 1, gap6 >= 40);
    foreach (q[k]) cmp("idle", 0, hs[q[k]]);
    slow <= 1;
    ev[3] <= 1;
    @(posedge clk) ev[3] <= 0;
    wreq(3); cmp("f3", {8'd9, 8'h10, 18'd9999, 1'b0, 10'd4, 16'd7, 2'd3, 1'b0}, fv);
    cd[4] <= 1;
    @(posedge clk) cd[4] <= 0;
    wreq(4); cmp("f4", {8'd2, 8'h0f, 18'd20, 1'b1, 10'd800, 16'd7, 2'd0, 1'b0}, fv);
    @(posedge clk);
    cmp("cond_clr", {1'b1, 4'd4}, {cond_clr, cond_clr_idx});
    cmp("evt_once", 1, hs[3]);
    wr(12'h008, 1);
    wreq(1); cmp("f1", {8'd0, 8'h05, 18'd150000, 1'b1, 10'd1, 16'd7, 2'd0, 1'b1}, fv);
    $display("test scheduling done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      sw_v <= 1; sw_c <= k[1:0]; sw_d <= 32'h11223344;
      @(posedge clk) sw_v <= 0;
      @(posedge clk) cmp("swap", sx[k], sw_out_data);
    end
    $display("test swap done");
    wr(12'h000, 0);
    rd(12'h014); cmp("skips", 1, d != 0);
    end_of_test();
  end
endmodule // mms_cmd_sched_tb_top
